// [include/adc_cal_pkg.sv]
// Shared constants and types for the converter frame link and its host
package adc_cal_pkg;
	// Frame geometry
	localparam int          RESULT_W         = 14;
	localparam int          CNT_W            = 7;
	localparam logic [6:0]  CONV_CLKS        = 7'h12;   // 18 falling edges finish a conversion
	localparam logic [6:0]  POWERUP_CAL_CLKS = 7'h18;   // 24 clocks in the first frame
	localparam logic [6:0]  NORMAL_CAL_CLKS  = 7'h40;   // 64 clocks in a later frame
	localparam logic [6:0]  LAST_BIT_EDGE    = 7'h0E;   // Falls after which result bits are still shifting
	localparam logic [6:0]  CNT_MAX          = 7'h7F;
	localparam logic [13:0] INVALID_RESULT   = 14'h3FFF; // Reported after a short frame
	localparam logic [13:0] RESET_RESULT     = 14'h0000;

	// Timing
	localparam int          SYS_CLK_NS       = 20;
	localparam int          MIN_SAMPLE_NS    = 95;
	localparam int          MIN_SAMPLE_CYC_I = (MIN_SAMPLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [7:0]  MIN_SAMPLE_CYC   = 8'(MIN_SAMPLE_CYC_I);
	localparam int          SYNC_DEPTH       = 3;
	localparam logic [7:0]  SYNC_MARGIN_CYC  = 8'h04;   // Covers the far end's synchroniser delay
	localparam logic [7:0]  SCLK_HALF_CYC    = 8'h0A;   // 10 cycles high, 10 low: 400 ns period
	localparam logic [2:0]  SYNC_RESET_HI    = 3'h7;
	localparam logic [2:0]  SYNC_RESET_LO    = 3'h0;

	// Device functional states
	typedef enum logic [1:0] {
		sampling_state    = 2'b00,
		conversion_state  = 2'b01,
		offset_trim_state = 2'b10
	} adc_state_t;

	// Host frame states
	typedef enum logic [1:0] {
		host_idle  = 2'b00,
		host_frame = 2'b01,
		host_gap   = 2'b10
	} host_state_t;
endpackage

// [include/adc_link_if.sv]
// Serial link between the converter frame logic and its host
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic cs_b;
	logic sclk;
	logic sdo_o;
	logic sdo_oe;
	logic sdo_line;

	// Undriven data line settles low through the board keeper
	assign sdo_line = sdo_oe ? sdo_o : 1'b0;

	modport dev (
		input  cs_b,
		input  sclk,
		output sdo_o,
		output sdo_oe
	);

	modport host (
		output cs_b,
		output sclk,
		input  sdo_line
	);
endinterface
`default_nettype wire

// [core/adc_dev_end.sv]
// Converter end: frame decode, result shifting and offset trim entry
`timescale 1ns/1ps
`default_nettype none
module adc_dev_end (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	adc_link_if.dev                   link,
	input  wire logic [13:0]          sample_in,
	output adc_cal_pkg::adc_state_t   state,
	output logic                      conv_done,
	output logic                      cal_done,
	output logic                      cal_abort,
	output logic                      calibrated
);
	// Pin synchronisers and debounced levels
	logic [2:0] cs_sync_q;
	logic [2:0] ck_sync_q;
	logic       cs_lvl_q;
	logic       cs_lvl_d;
	logic       ck_lvl_q;
	logic       ck_lvl_d;
	logic       cs_fall;
	logic       cs_rise;
	logic       ck_fall;
	logic       ck_rise;

	// Frame state
	adc_cal_pkg::adc_state_t st_q;
	adc_cal_pkg::adc_state_t st_d;
	logic [6:0]  cnt_q;
	logic [6:0]  cnt_d;
	logic [6:0]  cnt_next;
	logic [6:0]  cal_target;
	logic        first_q;
	logic        first_d;
	logic        bad_q;
	logic        bad_d;
	logic        conv_ok_q;
	logic        conv_ok_d;
	logic        done_q;
	logic        done_d;
	logic        calib_q;
	logic        calib_d;
	logic [13:0] held_q;
	logic [13:0] held_d;
	logic [13:0] result_q;
	logic [13:0] result_d;
	logic [13:0] shift_q;
	logic [13:0] shift_d;
	logic        sdo_q;
	logic        sdo_d;
	logic        oe_q;
	logic        oe_d;
	logic        conv_done_q;
	logic        conv_done_d;
	logic        cal_done_q;
	logic        cal_done_d;
	logic        cal_abort_q;
	logic        cal_abort_d;

	// A level counts only once the second and third stages agree
	always_comb begin
		cs_lvl_d = cs_lvl_q;
		ck_lvl_d = ck_lvl_q;
		if (cs_sync_q[1] == cs_sync_q[2]) begin
			cs_lvl_d = cs_sync_q[2];
		end
		if (ck_sync_q[1] == ck_sync_q[2]) begin
			ck_lvl_d = ck_sync_q[2];
		end
	end

	assign cs_fall = cs_lvl_q && !cs_lvl_d;
	assign cs_rise = !cs_lvl_q && cs_lvl_d;
	assign ck_fall = ck_lvl_q && !ck_lvl_d;
	assign ck_rise = !ck_lvl_q && ck_lvl_d;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_sync_q <= adc_cal_pkg::SYNC_RESET_HI;
			ck_sync_q <= adc_cal_pkg::SYNC_RESET_LO;
			cs_lvl_q  <= 1'b1;
			ck_lvl_q  <= 1'b0;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], link.cs_b};
			ck_sync_q <= {ck_sync_q[1:0], link.sclk};
			cs_lvl_q  <= cs_lvl_d;
			ck_lvl_q  <= ck_lvl_d;
		end
	end

	// Count saturates so a very long frame cannot wrap into a false match
	assign cnt_next   = (cnt_q == adc_cal_pkg::CNT_MAX) ? cnt_q : cnt_q + 7'h01;
	assign cal_target = first_q ? adc_cal_pkg::POWERUP_CAL_CLKS
	                            : adc_cal_pkg::NORMAL_CAL_CLKS;

	// Frame sequencing: chip-select edges first, then serial clock edges
	always_comb begin
		st_d        = st_q;
		cnt_d       = cnt_q;
		first_d     = first_q;
		bad_d       = bad_q;
		conv_ok_d   = conv_ok_q;
		done_d      = done_q;
		calib_d     = calib_q;
		held_d      = held_q;
		result_d    = result_q;
		shift_d     = shift_q;
		sdo_d       = sdo_q;
		oe_d        = oe_q;
		conv_done_d = 1'b0;
		cal_done_d  = 1'b0;
		cal_abort_d = 1'b0;
		if (cs_fall) begin
			cnt_d     = 7'h00;
			oe_d      = 1'b1;
			sdo_d     = 1'b0;
			held_d    = sample_in;
			conv_ok_d = 1'b0;
			done_d    = 1'b0;
			// First frame shifts zeros; a short previous frame reports garbage
			if (first_q) begin
				shift_d = adc_cal_pkg::RESET_RESULT;
				st_d    = adc_cal_pkg::offset_trim_state;
			end else begin
				shift_d = bad_q ? adc_cal_pkg::INVALID_RESULT : result_q;
				st_d    = adc_cal_pkg::conversion_state;
			end
		end else if (cs_rise) begin
			oe_d    = 1'b0;
			sdo_d   = 1'b0;
			bad_d   = !conv_ok_q;
			first_d = 1'b0;
			if (st_q == adc_cal_pkg::offset_trim_state) begin
				cal_abort_d = 1'b1;
			end
			st_d = adc_cal_pkg::sampling_state;
		end else if (oe_q) begin
			if (ck_fall) begin
				cnt_d = cnt_next;
				if (cnt_next == adc_cal_pkg::CONV_CLKS) begin
					result_d    = held_q;
					conv_ok_d   = 1'b1;
					conv_done_d = 1'b1;
					if (st_q == adc_cal_pkg::conversion_state) begin
						st_d = adc_cal_pkg::sampling_state;
					end
				end
				// Clocks beyond the conversion mean the host wants a trim
				if ((cnt_next == adc_cal_pkg::CONV_CLKS + 7'h01) && !done_q && !first_q &&
				    (st_q == adc_cal_pkg::sampling_state)) begin
					st_d = adc_cal_pkg::offset_trim_state;
				end
				if ((st_q == adc_cal_pkg::offset_trim_state) && (cnt_next == cal_target)) begin
					done_d     = 1'b1;
					cal_done_d = 1'b1;
					calib_d    = 1'b1;
					st_d       = adc_cal_pkg::sampling_state;
				end
			end
			// Bits launch on rising edges after the first fall; shift register empties to zeros
			if (ck_rise && (cnt_q != 7'h00)) begin
				sdo_d   = shift_q[13];
				shift_d = {shift_q[12:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q        <= adc_cal_pkg::sampling_state;
			cnt_q       <= 7'h00;
			first_q     <= 1'b1;
			bad_q       <= 1'b0;
			conv_ok_q   <= 1'b0;
			done_q      <= 1'b0;
			calib_q     <= 1'b0;
			held_q      <= adc_cal_pkg::RESET_RESULT;
			result_q    <= adc_cal_pkg::RESET_RESULT;
			shift_q     <= adc_cal_pkg::RESET_RESULT;
			sdo_q       <= 1'b0;
			oe_q        <= 1'b0;
			conv_done_q <= 1'b0;
			cal_done_q  <= 1'b0;
			cal_abort_q <= 1'b0;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			first_q     <= first_d;
			bad_q       <= bad_d;
			conv_ok_q   <= conv_ok_d;
			done_q      <= done_d;
			calib_q     <= calib_d;
			held_q      <= held_d;
			result_q    <= result_d;
			shift_q     <= shift_d;
			sdo_q       <= sdo_d;
			oe_q        <= oe_d;
			conv_done_q <= conv_done_d;
			cal_done_q  <= cal_done_d;
			cal_abort_q <= cal_abort_d;
		end
	end

	// Outputs straight from flip-flops
	assign link.sdo_o  = sdo_q;
	assign link.sdo_oe = oe_q;
	assign state       = st_q;
	assign conv_done   = conv_done_q;
	assign cal_done    = cal_done_q;
	assign cal_abort   = cal_abort_q;
	assign calibrated  = calib_q;
endmodule
`default_nettype wire

// [core/adc_host_end.sv]
// Host end: frames chip select, divides the serial clock, collects results
`timescale 1ns/1ps
`default_nettype none
module adc_host_end (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	adc_link_if.host         link,
	input  wire logic        start,
	input  wire logic        cal_mode,
	output logic             ready,
	output logic [13:0]      rx_data,
	output logic             rx_valid
);
	adc_cal_pkg::host_state_t st_q;
	adc_cal_pkg::host_state_t st_d;
	logic [2:0]  sdo_sync_q;
	logic        sdo_lvl_q;
	logic        sdo_lvl_d;
	logic [7:0]  div_q;
	logic [7:0]  div_d;
	logic [6:0]  edges_q;
	logic [6:0]  edges_d;
	logic [6:0]  target_q;
	logic [6:0]  target_d;
	logic        first_q;
	logic        first_d;
	logic        cs_b_q;
	logic        cs_b_d;
	logic        sclk_q;
	logic        sclk_d;
	logic [13:0] shift_q;
	logic [13:0] shift_d;
	logic [13:0] rx_q;
	logic [13:0] rx_d;
	logic        rx_valid_q;
	logic        rx_valid_d;

	// Data pin is taken only when the second and third stages agree
	always_comb begin
		sdo_lvl_d = sdo_lvl_q;
		if (sdo_sync_q[1] == sdo_sync_q[2]) begin
			sdo_lvl_d = sdo_sync_q[2];
		end
	end

	// Frame sequencer; the divider period leaves room for both synchronisers
	always_comb begin
		st_d       = st_q;
		div_d      = div_q;
		edges_d    = edges_q;
		target_d   = target_q;
		first_d    = first_q;
		cs_b_d     = cs_b_q;
		sclk_d     = sclk_q;
		shift_d    = shift_q;
		rx_d       = rx_q;
		rx_valid_d = 1'b0;
		case (st_q)
			adc_cal_pkg::host_idle: begin
				if (start) begin
					cs_b_d  = 1'b0;
					div_d   = 8'h00;
					edges_d = 7'h00;
					if (!cal_mode) begin
						target_d = adc_cal_pkg::CONV_CLKS;
					end else if (first_q) begin
						target_d = adc_cal_pkg::POWERUP_CAL_CLKS;
					end else begin
						target_d = adc_cal_pkg::NORMAL_CAL_CLKS;
					end
					st_d = adc_cal_pkg::host_frame;
				end
			end
			adc_cal_pkg::host_frame: begin
				if (div_q == adc_cal_pkg::SCLK_HALF_CYC - 8'h01) begin
					div_d = 8'h00;
					if (edges_q == target_q) begin
						// Last low phase done: close the frame
						cs_b_d  = 1'b1;
						first_d = 1'b0;
						st_d    = adc_cal_pkg::host_gap;
						if (target_q != adc_cal_pkg::CONV_CLKS) begin
							rx_valid_d = 1'b0;
						end
						if (edges_q >= adc_cal_pkg::CONV_CLKS) begin
							rx_d       = shift_q;
							rx_valid_d = 1'b1;
						end
					end else if (sclk_q) begin
						// Sample just before falls 2 to 15; bits ride after the leading zero
						sclk_d  = 1'b0;
						edges_d = edges_q + 7'h01;
						if ((edges_q != 7'h00) && (edges_q <= adc_cal_pkg::LAST_BIT_EDGE)) begin
							shift_d = {shift_q[12:0], sdo_lvl_q};
						end
					end else begin
						sclk_d = 1'b1;
					end
				end else begin
					div_d = div_q + 8'h01;
				end
			end
			adc_cal_pkg::host_gap: begin
				// Sampling time after every frame, trim frames included
				if (div_q == adc_cal_pkg::MIN_SAMPLE_CYC + adc_cal_pkg::SYNC_MARGIN_CYC) begin
					div_d = 8'h00;
					st_d  = adc_cal_pkg::host_idle;
				end else begin
					div_d = div_q + 8'h01;
				end
			end
			default: begin
				st_d   = adc_cal_pkg::host_idle;
				cs_b_d = 1'b1;
				sclk_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q       <= adc_cal_pkg::host_idle;
			sdo_sync_q <= adc_cal_pkg::SYNC_RESET_LO;
			sdo_lvl_q  <= 1'b0;
			div_q      <= 8'h00;
			edges_q    <= 7'h00;
			target_q   <= adc_cal_pkg::CONV_CLKS;
			first_q    <= 1'b1;
			cs_b_q     <= 1'b1;
			sclk_q     <= 1'b0;
			shift_q    <= adc_cal_pkg::RESET_RESULT;
			rx_q       <= adc_cal_pkg::RESET_RESULT;
			rx_valid_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			sdo_sync_q <= {sdo_sync_q[1:0], link.sdo_line};
			sdo_lvl_q  <= sdo_lvl_d;
			div_q      <= div_d;
			edges_q    <= edges_d;
			target_q   <= target_d;
			first_q    <= first_d;
			cs_b_q     <= cs_b_d;
			sclk_q     <= sclk_d;
			shift_q    <= shift_d;
			rx_q       <= rx_d;
			rx_valid_q <= rx_valid_d;
		end
	end

	assign link.cs_b = cs_b_q;
	assign link.sclk = sclk_q;
	assign ready     = (st_q == adc_cal_pkg::host_idle);
	assign rx_data   = rx_q;
	assign rx_valid  = rx_valid_q;
endmodule
`default_nettype wire

// [verification/adc_link_checker.sv]
// Concurrent checks on the serial link between the converter end and its host
`timescale 1ns/1ps
`default_nettype none
module adc_link_checker (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sclk,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic sdo_line
);
	logic [6:0] falls_q, falls_d;
	logic       sclk_q, sclk_d, cs_q, cs_d, first_q, first_d;

	// Raw serial falls per frame; raw edges lead the far end's synchronised view
	always_comb begin
		sclk_d  = sclk;
		cs_d    = cs_b;
		first_d = first_q && !(cs_b && !cs_q);
		falls_d = falls_q;
		if (!cs_b && cs_q)
			falls_d = 7'h00;
		else if (!cs_b && sclk_q && !sclk)
			falls_d = falls_q + 7'h01;
	end

	// Helper registers, cleared like a power-up
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q  <= 1'h0;
			cs_q    <= 1'h1;
			falls_q <= 7'h00;
			first_q <= 1'h1;
		end else begin
			sclk_q  <= sclk_d;
			cs_q    <= cs_d;
			falls_q <= falls_d;
			first_q <= first_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// Frame boundaries seen on the wire
	sequence frame_open;
		$fell(cs_b);
	endsequence
	sequence frame_close;
		$rose(cs_b);
	endsequence

	// Windows allow for the three-flop synchroniser lag at the converter end
	frame_drive_a: assert property (frame_open |-> ##[1:8] sdo_oe) else $error("no drive after frame start");
	idle_release_a: assert property (cs_b [*8] |-> !sdo_oe) else $error("data driven while deselected");
	lead_zero_a: assert property ($rose(sdo_oe) |-> !sdo_line && !cs_b) else $error("no leading zero");
	sample_gap_a: assert property (frame_close |=> cs_b [*5]) else $error("sampling gap too short");
	enough_falls_a: assert property (frame_close |-> falls_q >= 7'h12) else $error("short frame");
	count_cap_a: assert property (frame_close |-> falls_q <= 7'h40) else $error("frame too long");
	clock_rate_a: assert property ($changed(sclk) |=> $stable(sclk) [*2]) else $error("serial clock too fast");
	first_zero_a: assert property (first_q && sdo_oe |-> !sdo_o) else $error("data in first frame");
	tail_zero_a: assert property (sdo_oe && falls_q >= 7'h10 |-> !sdo_o) else $error("tail not zero");
	bit_hold_a: assert property ($fell(sclk) && !cs_b |-> $stable(sdo_o) [*8]) else $error("bit moved");
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench: host and converter ends joined, plus a driven second converter end
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic        mode;
		logic [13:0] smp;
		logic [13:0] rx;
	} row_t;

	logic                     sys_clk, rst_b, start, cal_mode;
	logic [13:0]              sample, rx_data;
	logic                     ready, rx_valid, calibrated, conv_done, cal_done;
	logic                     cal_abort_b, calibrated_b;
	adc_cal_pkg::adc_state_t  state, state_b;
	int                       n_fail = 0, checks_done = 0, n_cal = 0, n_conv = 0, n_trim = 0;
	int                       n_abort_b = 0, n_trim_b = 0;
	row_t                     rows [5];

	adc_link_if link ();
	adc_link_if link_b ();

	adc_dev_end i_adc_dev_end (.sys_clk(sys_clk), .rst_b(rst_b), .link(link.dev), .sample_in(sample),
		.state(state), .conv_done(conv_done), .cal_done(cal_done), .cal_abort(), .calibrated(calibrated));
	adc_host_end i_adc_host_end (.sys_clk(sys_clk), .rst_b(rst_b), .link(link.host), .start(start),
		.cal_mode(cal_mode), .ready(ready), .rx_data(rx_data), .rx_valid(rx_valid));
	// Second converter end, driven by the bench so frames can be cut short
	adc_dev_end i_adc_dev_end_b (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_b.dev), .sample_in(sample),
		.state(state_b), .conv_done(), .cal_done(), .cal_abort(cal_abort_b), .calibrated(calibrated_b));
	adc_link_checker i_adc_link_checker (.sys_clk(sys_clk), .rst_b(rst_b), .cs_b(link.cs_b),
		.sclk(link.sclk), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));

	// 50 MHz system clock
	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Pulse and trim-state cycle tallies taken on the falling edge, where outputs have settled
	always @(negedge sys_clk) begin
		n_cal     += (cal_done === 1'h1);
		n_conv    += (conv_done === 1'h1);
		n_trim    += (state === adc_cal_pkg::offset_trim_state);
		n_abort_b += (cal_abort_b === 1'h1);
		n_trim_b  += (state_b === adc_cal_pkg::offset_trim_state);
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded wait for ready or rx_valid; a selector avoids ref arguments that some simulators refuse
	task automatic wait_for(input bit want_ready, input string what);
		for (int k = 0; k < 3000 && (want_ready ? ready : rx_valid) !== 1'h1; k++)
			@(negedge sys_clk);
		if ((want_ready ? ready : rx_valid) !== 1'h1) begin
			chk(what, 1, 0);
			tally_and_finish();
		end
	endtask

	// Bench-made frame: 160 ns serial clock, bit read just before the next rise
	task automatic drive_frame(input int n, output logic [63:0] bits);
		bits = 64'h0;
		@(posedge sys_clk) link_b.cs_b <= 1'h0;
		repeat (8) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			link_b.sclk <= 1'h1;
			repeat (4) @(posedge sys_clk);
			link_b.sclk <= 1'h0;
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk) bits = {bits[62:0], link_b.sdo_line};
			@(posedge sys_clk);
		end
		link_b.cs_b <= 1'h1;
		repeat (10) @(posedge sys_clk);
	endtask

	// One host frame: start it, check the result and the pulses it caused
	task automatic run_row(input row_t r);
		int c_cal, c_conv, c_trim;
		c_cal = n_cal;
		c_conv = n_conv;
		c_trim = n_trim;
		@(posedge sys_clk);
		sample <= r.smp;
		cal_mode <= r.mode;
		start <= 1'h1;
		@(posedge sys_clk) start <= 1'h0;
		wait_for(1'h0, "rx_valid");
		chk("rx_data", 32'(r.rx), 32'(rx_data));
		wait_for(1'h1, "ready");
		chk("cal_done", 32'(r.mode), n_cal - c_cal);
		chk("conv_done", 1, n_conv - c_conv);
		chk("trim", 32'(r.mode), 32'(n_trim > c_trim));
		chk("calibrated", 1, 32'(calibrated));
	endtask

	// Main sequence
	initial begin
		logic [63:0] bits;
		rows[0] = {1'h1, 14'h2A5C, 14'h0000};
		rows[1] = {1'h0, 14'h1234, 14'h2A5C};
		rows[2] = {1'h1, 14'h3FFF, 14'h1234};
		rows[3] = {1'h0, 14'h0001, 14'h3FFF};
		rows[4] = {1'h0, 14'h2000, 14'h0001};
		rst_b = 1'h0;
		start = 1'h0;
		cal_mode = 1'h0;
		sample = 14'h0000;
		link_b.cs_b = 1'h1;
		link_b.sclk = 1'h0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'h1;
		@(negedge sys_clk);
		chk("cs_b", 1, link.cs_b);
		chk("sdo_oe", 0, link.sdo_oe);
		chk("calibrated", 0, calibrated);
		chk("state", adc_cal_pkg::sampling_state, state);
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		// Two cut frames, then a full trim frame, on the second converter end; its sample input still holds the last row's value
		drive_frame(10, bits);
		chk("first bits", 0, bits[9:0]);
		chk("aborts", 1, n_abort_b);
		chk("trim b", 1, n_trim_b > 0);
		chk("state b", adc_cal_pkg::sampling_state, state_b);
		drive_frame(30, bits);
		chk("short bits", {1'h0, adc_cal_pkg::INVALID_RESULT, 15'h0000}, bits[29:0]);
		chk("aborts", 2, n_abort_b);
		chk("cal b", 0, calibrated_b);
		drive_frame(64, bits);
		chk("trim bits", {1'h0, rows[4].smp, 17'h00000}, bits[63:32]);
		chk("trim tail", 0, bits[31:0]);
		chk("cal b", 1, calibrated_b);
		$display("abort test done");
		// Reset in mid-frame must bring back the first-frame behaviour
		@(posedge sys_clk) start <= 1'h1;
		@(posedge sys_clk) start <= 1'h0;
		repeat (200) @(posedge sys_clk);
		rst_b <= 1'h0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("cs_b", 1, link.cs_b);
		chk("calibrated", 0, calibrated);
		@(posedge sys_clk) rst_b <= 1'h1;
		run_row(rows[0]);
		$display("second reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
